// ### logic/mac_stats_pkg.sv
// shared constants and types for the mac statistics event block
package mac_stats_pkg;

	// counter widths, and frame size limits in bytes including the checksum
	localparam int unsigned BYTE_COUNT_W    = 16;
	localparam int unsigned TOTAL_W         = 64;
	localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
	localparam logic [15:0] DEF_MAX_BYTES   = 16'h05ee;

	// reset values
	localparam logic [15:0] BYTES_RESET     = 16'h0000;
	localparam logic [63:0] TOTAL_RESET     = 64'h0000_0000_0000_0000;

	// destination address class of a received frame
	typedef enum logic [1:0]
	{
		CAST_UNICAST,
		CAST_MULTICAST,
		CAST_BROADCAST
	} cast_e;

endpackage

// ### logic/frame_error_sort.sv
// sorts one finished frame into size and checksum error classes
`timescale 1ns/10ps
`default_nettype none

module frame_error_sort
	import mac_stats_pkg::*;
(
	input  wire logic [15:0] frame_bytes,
	input  wire logic [15:0] max_bytes,
	input  wire logic        checksum_bad,
	input  wire logic        length_field_bad,
	output logic             undersize,
	output logic             oversize,
	output logic             fragment,
	output logic             jabber,
	output logic             size_good_checksum_bad,
	output logic             errored
);

	always_comb
	begin
		undersize              = frame_bytes < MIN_FRAME_BYTES;
		oversize               = frame_bytes > max_bytes;
		fragment               = undersize & checksum_bad;
		jabber                 = oversize & checksum_bad;
		size_good_checksum_bad = ~undersize & ~oversize & checksum_bad;
		// qualifying frames are those with none of these set
		errored = checksum_bad | undersize | oversize | length_field_bad;
	end

endmodule // frame_error_sort

`default_nettype wire

// ### logic/octet_tally.sv
// per-frame payload byte count with strobe, and running byte total
`timescale 1ns/10ps
`default_nettype none

module octet_tally
	import mac_stats_pkg::*;
#(
	parameter int unsigned COUNT_W        = BYTE_COUNT_W,
	parameter int unsigned SUM_W          = TOTAL_W,
	parameter bit          TOTALS_PRESENT = 1'b1
)
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	input  wire logic               frame_done,
	input  wire logic               qualifies,
	input  wire logic [COUNT_W-1:0] payload_bytes,
	output logic      [COUNT_W-1:0] frame_bytes,
	output logic                    frame_bytes_strobe,
	output logic      [SUM_W-1:0]   byte_total
);

	typedef struct packed
	{
		logic [COUNT_W-1:0] bytes;
		logic               strobe;
		logic [SUM_W-1:0]   total;
	} tally_s;

	tally_s tally_reg;
	tally_s tally_next;

	always_comb
	begin
		tally_next        = tally_reg;
		if (ce)
		begin
			tally_next.strobe = 1'b0;
			if (frame_done && qualifies)
			begin
				tally_next.bytes  = payload_bytes;
				tally_next.strobe = 1'b1;
				if (TOTALS_PRESENT)
					tally_next.total = tally_reg.total
						+ SUM_W'(payload_bytes);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tally_reg <= '{
				bytes:  COUNT_W'(BYTES_RESET),
				strobe: 1'b0,
				total:  SUM_W'(TOTAL_RESET)
			};
		else
			tally_reg <= tally_next;
	end

	// per-frame outputs run whether or not totals are kept
	assign frame_bytes        = tally_reg.bytes;
	assign frame_bytes_strobe = tally_reg.strobe;
	assign byte_total         = tally_reg.total;

endmodule // octet_tally

`default_nettype wire

// ### logic/mac_rx_stats_octet_pulses.sv
// receive statistics pulses and octet count outputs of the mac
// Summary of operation
// - separate pulses for bad and good multicast data frames, control frames excluded.
// - separate pulses for bad and good broadcast data frames.
// - separate pulses for bad and good unicast data frames.
// - pulse per good control frame of each cast type.
// - one pulse per good pause frame received.
// - one pulse per frame with a checksum error.
// - fragment pulse when frame below 64 bytes with checksum error.
// - jabber pulse when oversized frame has checksum error.
// - pulse when frame size is fine but checksum is bad.
// - pulse for each errored pause frame.
// - separate pulses for errored control frames of each cast type.
// - 64-bit receive and transmit totals of qualifying payload bytes.
// - each direction gives a 16-bit per-frame byte count with strobe.
// - byte strobe fires only for frames free of all four errors.
// - per-frame byte outputs work even without the totals.
// - both directions' octet outputs belong to the one shared clock, clk.
`timescale 1ns/10ps
`default_nettype none

module mac_rx_stats_octet_pulses
	import mac_stats_pkg::*;
#(
	parameter bit TOTALS_PRESENT = 1'b1
)
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	// receive frame descriptor, one cycle at frame end
	input  wire logic                 rx_frame_done,
	input  wire mac_stats_pkg::cast_e rx_cast,
	input  wire logic                 rx_is_control,
	input  wire logic                 rx_is_pause,
	input  wire logic [15:0]          rx_frame_len,
	input  wire logic [15:0]          rx_payload_len,
	input  wire logic                 rx_checksum_bad,
	input  wire logic                 rx_length_field_bad,
	input  wire logic [15:0]          rx_max_frame_bytes,
	// transmit frame descriptor, one cycle at frame end
	input  wire logic                 tx_frame_done,
	input  wire logic [15:0]          tx_frame_len,
	input  wire logic [15:0]          tx_payload_len,
	input  wire logic                 tx_checksum_bad,
	input  wire logic                 tx_length_field_bad,
	input  wire logic [15:0]          tx_max_frame_bytes,
	// receive event pulses
	output logic                      rx_mcast_data_bad_pulse,
	output logic                      rx_mcast_data_good_pulse,
	output logic                      rx_bcast_data_bad_pulse,
	output logic                      rx_bcast_data_good_pulse,
	output logic                      rx_ucast_data_bad_pulse,
	output logic                      rx_ucast_data_good_pulse,
	output logic                      rx_mcast_ctrl_pulse,
	output logic                      rx_bcast_ctrl_pulse,
	output logic                      rx_ucast_ctrl_pulse,
	output logic                      rx_pause_pulse,
	output logic                      rx_checksum_bad_pulse,
	output logic                      rx_fragment_pulse,
	output logic                      rx_jabber_pulse,
	output logic                      rx_size_good_checksum_bad_pulse,
	output logic                      rx_pause_bad_pulse,
	output logic                      rx_mcast_ctrl_bad_pulse,
	output logic                      rx_bcast_ctrl_bad_pulse,
	output logic                      rx_ucast_ctrl_bad_pulse,
	// octet count outputs
	output logic [15:0]               rx_frame_payload_bytes,
	output logic                      rx_frame_payload_bytes_strobe,
	output logic [63:0]               rx_good_payload_byte_total,
	output logic [15:0]               tx_frame_payload_bytes,
	output logic                      tx_frame_payload_bytes_strobe,
	output logic [63:0]               tx_good_payload_byte_total
);

	typedef struct packed
	{
		logic mcast_data_bad;
		logic mcast_data_good;
		logic bcast_data_bad;
		logic bcast_data_good;
		logic ucast_data_bad;
		logic ucast_data_good;
		logic mcast_ctrl;
		logic bcast_ctrl;
		logic ucast_ctrl;
		logic pause;
		logic checksum_bad;
		logic fragment;
		logic jabber;
		logic size_good_checksum_bad;
		logic pause_bad;
		logic mcast_ctrl_bad;
		logic bcast_ctrl_bad;
		logic ucast_ctrl_bad;
	} pulse_s;

	pulse_s pulse_reg;
	pulse_s pulse_next;

	logic   rx_undersize;
	logic   rx_oversize;
	logic   rx_fragment;
	logic   rx_jabber;
	logic   rx_size_good_checksum_bad;
	logic   rx_errored;
	logic   tx_errored;
	logic   is_ucast;
	logic   is_mcast;
	logic   is_bcast;
	logic   rx_good;
	logic   rx_data;

	frame_error_sort rx_sort
	(
		.frame_bytes            (rx_frame_len),
		.max_bytes              (rx_max_frame_bytes),
		.checksum_bad           (rx_checksum_bad),
		.length_field_bad       (rx_length_field_bad),
		.undersize              (rx_undersize),
		.oversize               (rx_oversize),
		.fragment               (rx_fragment),
		.jabber                 (rx_jabber),
		.size_good_checksum_bad (rx_size_good_checksum_bad),
		.errored                (rx_errored)
	);

	frame_error_sort tx_sort
	(
		.frame_bytes            (tx_frame_len),
		.max_bytes              (tx_max_frame_bytes),
		.checksum_bad           (tx_checksum_bad),
		.length_field_bad       (tx_length_field_bad),
		.undersize              (),
		.oversize               (),
		.fragment               (),
		.jabber                 (),
		.size_good_checksum_bad (),
		.errored                (tx_errored)
	);

	// destination class decode; the fourth code names no class
	always_comb
	begin
		is_ucast = 1'b0;
		is_mcast = 1'b0;
		is_bcast = 1'b0;
		unique case (rx_cast)
			CAST_UNICAST:   is_ucast = 1'b1;
			CAST_MULTICAST: is_mcast = 1'b1;
			CAST_BROADCAST: is_bcast = 1'b1;
			default:
			begin
				is_ucast = 1'b0;
			end
		endcase
	end

	assign rx_good = ~rx_errored;
	assign rx_data = ~rx_is_control;

	always_comb
	begin
		pulse_next = pulse_reg;
		if (ce)
		begin
			// pulses drop after one cycle unless a new frame ends
			pulse_next = '0;
			if (rx_frame_done)
			begin
				pulse_next.mcast_data_good =
					is_mcast & rx_data & rx_good;
				pulse_next.mcast_data_bad  =
					is_mcast & rx_data & rx_errored;
				pulse_next.bcast_data_bad  =
					is_bcast & rx_data & rx_errored;
				pulse_next.bcast_data_good =
					is_bcast & rx_data & rx_good;
				pulse_next.ucast_data_bad  =
					is_ucast & rx_data & rx_errored;
				pulse_next.ucast_data_good =
					is_ucast & rx_data & rx_good;
				pulse_next.mcast_ctrl =
					is_mcast & rx_is_control & rx_good;
				pulse_next.bcast_ctrl =
					is_bcast & rx_is_control & rx_good;
				pulse_next.ucast_ctrl =
					is_ucast & rx_is_control & rx_good;
				pulse_next.pause = rx_is_pause & rx_good;
				pulse_next.checksum_bad = rx_checksum_bad;
				pulse_next.fragment = rx_fragment;
				pulse_next.jabber = rx_jabber;
				pulse_next.size_good_checksum_bad =
					rx_size_good_checksum_bad;
				pulse_next.pause_bad = rx_is_pause & rx_errored;
				pulse_next.mcast_ctrl_bad =
					is_mcast & rx_is_control & rx_errored;
				pulse_next.bcast_ctrl_bad =
					is_bcast & rx_is_control & rx_errored;
				pulse_next.ucast_ctrl_bad =
					is_ucast & rx_is_control & rx_errored;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pulse_reg <= '0;
		else
			pulse_reg <= pulse_next;
	end

	assign rx_mcast_data_bad_pulse         = pulse_reg.mcast_data_bad;
	assign rx_mcast_data_good_pulse        = pulse_reg.mcast_data_good;
	assign rx_bcast_data_bad_pulse         = pulse_reg.bcast_data_bad;
	assign rx_bcast_data_good_pulse        = pulse_reg.bcast_data_good;
	assign rx_ucast_data_bad_pulse         = pulse_reg.ucast_data_bad;
	assign rx_ucast_data_good_pulse        = pulse_reg.ucast_data_good;
	assign rx_mcast_ctrl_pulse             = pulse_reg.mcast_ctrl;
	assign rx_bcast_ctrl_pulse             = pulse_reg.bcast_ctrl;
	assign rx_ucast_ctrl_pulse             = pulse_reg.ucast_ctrl;
	assign rx_pause_pulse                  = pulse_reg.pause;
	assign rx_checksum_bad_pulse           = pulse_reg.checksum_bad;
	assign rx_fragment_pulse               = pulse_reg.fragment;
	assign rx_jabber_pulse                 = pulse_reg.jabber;
	assign rx_size_good_checksum_bad_pulse = pulse_reg.size_good_checksum_bad;
	assign rx_pause_bad_pulse              = pulse_reg.pause_bad;
	assign rx_mcast_ctrl_bad_pulse         = pulse_reg.mcast_ctrl_bad;
	assign rx_bcast_ctrl_bad_pulse         = pulse_reg.bcast_ctrl_bad;
	assign rx_ucast_ctrl_bad_pulse         = pulse_reg.ucast_ctrl_bad;

	// both directions share clk in this build
	octet_tally
	#(
		.COUNT_W        (BYTE_COUNT_W),
		.SUM_W          (TOTAL_W),
		.TOTALS_PRESENT (TOTALS_PRESENT)
	)
	rx_tally
	(
		.clk                (clk),
		.rst_n              (rst_n),
		.ce                 (ce),
		.frame_done         (rx_frame_done),
		.qualifies          (~rx_errored),
		.payload_bytes      (rx_payload_len),
		.frame_bytes        (rx_frame_payload_bytes),
		.frame_bytes_strobe (rx_frame_payload_bytes_strobe),
		.byte_total         (rx_good_payload_byte_total)
	);

	octet_tally
	#(
		.COUNT_W        (BYTE_COUNT_W),
		.SUM_W          (TOTAL_W),
		.TOTALS_PRESENT (TOTALS_PRESENT)
	)
	tx_tally
	(
		.clk                (clk),
		.rst_n              (rst_n),
		.ce                 (ce),
		.frame_done         (tx_frame_done),
		.qualifies          (~tx_errored),
		.payload_bytes      (tx_payload_len),
		.frame_bytes        (tx_frame_payload_bytes),
		.frame_bytes_strobe (tx_frame_payload_bytes_strobe),
		.byte_total         (tx_good_payload_byte_total)
	);

endmodule // mac_rx_stats_octet_pulses

`default_nettype wire

// ### tb/octet_client.sv
// client counter that sums per-frame byte counts
`timescale 1ns/10ps
`default_nettype none
module octet_client
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        strobe,
	input  wire logic [15:0] bytes,
	output logic      [63:0] sum_reg
);
	// count is meaningless outside the strobe
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			sum_reg <= 64'h0;
		else if (strobe)
			sum_reg <= sum_reg + 64'(bytes);
endmodule // octet_client
`default_nettype wire

// ### tb/mac_stats_properties.sv
// assertions on the statistics pulse and octet outputs
`timescale 1ns/10ps
`default_nettype none
module mac_stats_properties
	import mac_stats_pkg::*;
#(
	parameter bit TOTALS_PRESENT = 1'b1
)
(
	input wire logic clk, rst_n, ce, rx_frame_done, tx_frame_done,
	input wire logic rx_is_control, rx_is_pause, rx_checksum_bad,
	input wire logic rx_length_field_bad, tx_checksum_bad,
	input wire logic tx_length_field_bad,
	input wire mac_stats_pkg::cast_e rx_cast,
	input wire logic [15:0] rx_frame_len, rx_payload_len,
	input wire logic [15:0] rx_max_frame_bytes, tx_frame_len,
	input wire logic [15:0] tx_max_frame_bytes, rx_frame_payload_bytes,
	input wire logic rx_mcast_data_bad_pulse, rx_mcast_data_good_pulse,
	input wire logic rx_bcast_data_bad_pulse, rx_bcast_data_good_pulse,
	input wire logic rx_ucast_data_bad_pulse, rx_ucast_data_good_pulse,
	input wire logic rx_mcast_ctrl_pulse, rx_bcast_ctrl_pulse,
	input wire logic rx_ucast_ctrl_pulse, rx_pause_pulse,
	input wire logic rx_checksum_bad_pulse, rx_fragment_pulse,
	input wire logic rx_jabber_pulse, rx_size_good_checksum_bad_pulse,
	input wire logic rx_pause_bad_pulse, rx_mcast_ctrl_bad_pulse,
	input wire logic rx_bcast_ctrl_bad_pulse, rx_ucast_ctrl_bad_pulse,
	input wire logic rx_frame_payload_bytes_strobe,
	input wire logic tx_frame_payload_bytes_strobe,
	input wire logic [63:0] rx_good_payload_byte_total
);
	wire logic dat = !rx_is_control;
	wire logic cb = rx_checksum_bad;
	wire logic shrt = rx_frame_len < MIN_FRAME_BYTES;
	wire logic lng = rx_frame_len > rx_max_frame_bytes;
	wire logic errd = cb | shrt | lng | rx_length_field_bad;
	wire logic terr = tx_checksum_bad | tx_length_field_bad
		| (tx_frame_len < MIN_FRAME_BYTES) | (tx_frame_len > tx_max_frame_bytes);
	wire logic [2:0] cst = {rx_cast == CAST_MULTICAST,
		rx_cast == CAST_BROADCAST, rx_cast == CAST_UNICAST};

	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence rx_take;
		ce && rx_frame_done;
	endsequence
	sequence tx_take;
		ce && tx_frame_done;
	endsequence

	chk_mcast_data: assert property (rx_take |=>
		{rx_mcast_data_bad_pulse, rx_mcast_data_good_pulse}
		== $past({cst[2] & dat & errd, cst[2] & dat & !errd}))
		else $error("mcast data pulse wrong");
	chk_bcast_data: assert property (rx_take |=>
		{rx_bcast_data_bad_pulse, rx_bcast_data_good_pulse}
		== $past({cst[1] & dat & errd, cst[1] & dat & !errd}))
		else $error("bcast data pulse wrong");
	chk_ucast_data: assert property (rx_take |=>
		{rx_ucast_data_bad_pulse, rx_ucast_data_good_pulse}
		== $past({cst[0] & dat & errd, cst[0] & dat & !errd}))
		else $error("ucast data pulse wrong");
	chk_ctrl_good: assert property (rx_take |=>
		{rx_mcast_ctrl_pulse, rx_bcast_ctrl_pulse, rx_ucast_ctrl_pulse}
		== $past(cst & {3{!dat & !errd}})) else $error("ctrl pulse wrong");
	chk_pause_pair: assert property (rx_take |=>
		{rx_pause_pulse, rx_pause_bad_pulse}
		== $past({rx_is_pause & !errd, rx_is_pause & errd}))
		else $error("pause pulse wrong");
	chk_checksum_class: assert property (rx_take |=>
		{rx_checksum_bad_pulse, rx_fragment_pulse, rx_jabber_pulse,
		rx_size_good_checksum_bad_pulse}
		== $past({cb, cb & shrt, cb & lng, cb & !shrt & !lng}))
		else $error("checksum class pulse wrong");
	chk_ctrl_bad: assert property (rx_take |=>
		{rx_mcast_ctrl_bad_pulse, rx_bcast_ctrl_bad_pulse,
		rx_ucast_ctrl_bad_pulse} == $past(cst & {3{!dat & errd}}))
		else $error("ctrl bad pulse wrong");
	chk_rx_strobe: assert property (rx_take |=>
		rx_frame_payload_bytes_strobe == $past(!errd))
		else $error("rx strobe wrong");
	chk_rx_bytes: assert property (rx_take ##0 !errd |=>
		rx_frame_payload_bytes == $past(rx_payload_len)
		&& rx_good_payload_byte_total == $past(rx_good_payload_byte_total)
		+ (TOTALS_PRESENT ? 64'($past(rx_payload_len)) : 64'h0))
		else $error("rx byte count wrong");
	chk_tx_strobe: assert property (tx_take |=>
		tx_frame_payload_bytes_strobe == $past(!terr))
		else $error("tx strobe wrong");
	chk_single_shot: assert property (ce && !rx_frame_done |=>
		!rx_checksum_bad_pulse && !rx_pause_pulse
		&& !rx_frame_payload_bytes_strobe) else $error("pulse repeated");
endmodule // mac_stats_properties

bind mac_rx_stats_octet_pulses mac_stats_properties
	#(.TOTALS_PRESENT(TOTALS_PRESENT)) props (.*);
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the statistics pulse block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import mac_stats_pkg::*;
	typedef struct packed
	{
		cast_e       cast;
		logic        ctrl, pause;
		logic [15:0] len;
		logic        cb, lfb;
		logic [17:0] pulses;
		logic        stb;
	} row_s;
	logic clk, rst_n, ce, rx_frame_done, tx_frame_done, rx_is_control;
	logic rx_is_pause, rx_checksum_bad, rx_length_field_bad;
	logic tx_checksum_bad, tx_length_field_bad;
	logic rx_frame_payload_bytes_strobe, tx_frame_payload_bytes_strobe;
	cast_e rx_cast;
	logic [15:0] rx_frame_len, rx_payload_len, rx_max_frame_bytes;
	logic [15:0] tx_frame_len, tx_payload_len, tx_max_frame_bytes;
	logic [15:0] rx_frame_payload_bytes, tx_frame_payload_bytes;
	logic [63:0] rx_good_payload_byte_total, tx_good_payload_byte_total;
	logic [63:0] rx_seen, tx_seen, sum;
	logic [17:0] got;
	logic [15:0] lean_rx_bytes, lean_tx_bytes;
	logic        lean_rx_stb, lean_tx_stb;
	logic [63:0] lean_rx_total, lean_tx_total;
	int errors, checks;
	row_s rows [14] = '{
		'{CAST_MULTICAST, 1'h0, 1'h0, 16'h0040, 1'h0, 1'h0, 18'h10000, 1'h1},
		'{CAST_MULTICAST, 1'h0, 1'h0, 16'h0064, 1'h1, 1'h0, 18'h20090, 1'h0},
		'{CAST_BROADCAST, 1'h0, 1'h0, 16'h05ee, 1'h0, 1'h0, 18'h04000, 1'h1},
		'{CAST_BROADCAST, 1'h0, 1'h0, 16'h05ef, 1'h0, 1'h0, 18'h08000, 1'h0},
		'{CAST_UNICAST, 1'h0, 1'h0, 16'h00c8, 1'h0, 1'h0, 18'h01000, 1'h1},
		'{CAST_UNICAST, 1'h0, 1'h0, 16'h003f, 1'h1, 1'h0, 18'h020c0, 1'h0},
		'{CAST_UNICAST, 1'h0, 1'h0, 16'h0064, 1'h0, 1'h1, 18'h02000, 1'h0},
		'{CAST_MULTICAST, 1'h1, 1'h0, 16'h0040, 1'h0, 1'h0, 18'h00800, 1'h1},
		'{CAST_BROADCAST, 1'h1, 1'h1, 16'h0040, 1'h0, 1'h0, 18'h00500, 1'h1},
		'{CAST_UNICAST, 1'h1, 1'h0, 16'h0064, 1'h0, 1'h0, 18'h00200, 1'h1},
		'{CAST_MULTICAST, 1'h1, 1'h1, 16'h05ef, 1'h1, 1'h0, 18'h000ac, 1'h0},
		'{CAST_BROADCAST, 1'h1, 1'h0, 16'h0028, 1'h0, 1'h0, 18'h00002, 1'h0},
		'{CAST_UNICAST, 1'h1, 1'h0, 16'h0064, 1'h1, 1'h0, 18'h00091, 1'h0},
		'{cast_e'(2'h3), 1'h0, 1'h0, 16'h0064, 1'h0, 1'h0, 18'h00000, 1'h1}};

	mac_rx_stats_octet_pulses dut (.*,
		.rx_mcast_data_bad_pulse(got[17]), .rx_mcast_data_good_pulse(got[16]),
		.rx_bcast_data_bad_pulse(got[15]), .rx_bcast_data_good_pulse(got[14]),
		.rx_ucast_data_bad_pulse(got[13]), .rx_ucast_data_good_pulse(got[12]),
		.rx_mcast_ctrl_pulse(got[11]), .rx_bcast_ctrl_pulse(got[10]),
		.rx_ucast_ctrl_pulse(got[9]), .rx_pause_pulse(got[8]),
		.rx_checksum_bad_pulse(got[7]), .rx_fragment_pulse(got[6]),
		.rx_jabber_pulse(got[5]), .rx_size_good_checksum_bad_pulse(got[4]),
		.rx_pause_bad_pulse(got[3]), .rx_mcast_ctrl_bad_pulse(got[2]),
		.rx_bcast_ctrl_bad_pulse(got[1]), .rx_ucast_ctrl_bad_pulse(got[0]));
	octet_client rx_client (.clk(clk), .rst_n(rst_n), .sum_reg(rx_seen),
		.strobe(rx_frame_payload_bytes_strobe), .bytes(rx_frame_payload_bytes));
	octet_client tx_client (.clk(clk), .rst_n(rst_n), .sum_reg(tx_seen),
		.strobe(tx_frame_payload_bytes_strobe), .bytes(tx_frame_payload_bytes));
	// second copy with the totals left out
	mac_rx_stats_octet_pulses #(.TOTALS_PRESENT(1'b0)) lean (.*,
		.rx_mcast_data_bad_pulse(), .rx_mcast_data_good_pulse(),
		.rx_bcast_data_bad_pulse(), .rx_bcast_data_good_pulse(),
		.rx_ucast_data_bad_pulse(), .rx_ucast_data_good_pulse(),
		.rx_mcast_ctrl_pulse(), .rx_bcast_ctrl_pulse(),
		.rx_ucast_ctrl_pulse(), .rx_pause_pulse(),
		.rx_checksum_bad_pulse(), .rx_fragment_pulse(),
		.rx_jabber_pulse(), .rx_size_good_checksum_bad_pulse(),
		.rx_pause_bad_pulse(), .rx_mcast_ctrl_bad_pulse(),
		.rx_bcast_ctrl_bad_pulse(), .rx_ucast_ctrl_bad_pulse(),
		.rx_frame_payload_bytes(lean_rx_bytes),
		.rx_frame_payload_bytes_strobe(lean_rx_stb),
		.rx_good_payload_byte_total(lean_rx_total),
		.tx_frame_payload_bytes(lean_tx_bytes),
		.tx_frame_payload_bytes_strobe(lean_tx_stb),
		.tx_good_payload_byte_total(lean_tx_total));

	always #5 clk = ~clk;

	task automatic drive(input row_s r, input logic go);
		rx_frame_done = go;
		tx_frame_done = go;
		rx_cast = r.cast;
		rx_is_control = r.ctrl;
		rx_is_pause = r.pause;
		rx_frame_len = r.len;
		tx_frame_len = r.len;
		rx_payload_len = r.len - 16'h0012;
		tx_payload_len = r.len - 16'h0012;
		rx_checksum_bad = r.cb;
		tx_checksum_bad = r.cb;
		rx_length_field_bad = r.lfb;
		tx_length_field_bad = r.lfb;
	endtask

	task automatic chk_pulses(input logic [17:0] g, input logic [17:0] e);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED %0t pulses %h want %h", $time, g, e);
		end
	endtask

	task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED %0t value %h want %h", $time, g, e);
		end
	endtask

	task automatic close_out;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		clk = 1'h0;
		rst_n = 1'h0;
		ce = 1'h1;
		rx_max_frame_bytes = DEF_MAX_BYTES;
		tx_max_frame_bytes = DEF_MAX_BYTES;
		sum = 64'h0;
		drive(rows[0], 1'h0);
		repeat (16) @(negedge clk);
		rst_n = 1'h1;
		// back-to-back frames, one per cycle
		for (int i = 0; i < 14; i++)
		begin
			drive(rows[i], 1'h1);
			@(negedge clk);
			if (rows[i].stb)
				sum += 64'(rows[i].len - 16'h0012);
			chk_pulses(got, rows[i].pulses);
			chk_val(64'(rx_frame_payload_bytes_strobe), 64'(rows[i].stb));
			chk_val(64'(tx_frame_payload_bytes_strobe), 64'(rows[i].stb));
			if (rows[i].stb)
			begin
				chk_val(64'(tx_frame_payload_bytes), 64'(rows[i].len - 16'h0012));
				chk_val(64'({lean_rx_bytes, lean_tx_bytes}), 64'({2{rows[i].len - 16'h0012}}));
			end
			chk_val(64'({lean_rx_stb, lean_tx_stb}), 64'({2{rows[i].stb}}));
			chk_val(lean_rx_total | lean_tx_total, 64'h0);
			chk_val(rx_good_payload_byte_total, sum);
			chk_val(tx_good_payload_byte_total, sum);
		end
		drive(rows[1], 1'h0);
		@(negedge clk);
		chk_pulses(got, 18'h0);
		chk_val(rx_seen, sum);
		chk_val(tx_seen, sum);
		// clock enable low holds pulses and refuses a new frame
		drive(rows[0], 1'h1);
		sum += 64'(rows[0].len - 16'h0012);
		@(negedge clk);
		ce = 1'h0;
		@(negedge clk);
		chk_pulses(got, rows[0].pulses);
		chk_val(rx_good_payload_byte_total, sum);
		ce = 1'h1;
		drive(rows[0], 1'h0);
		@(negedge clk);
		chk_pulses(got, 18'h0);
		chk_val(rx_good_payload_byte_total, sum);
		// reset in mid-run clears pending pulses and totals at once
		drive(rows[2], 1'h1);
		@(negedge clk);
		drive(rows[2], 1'h0);
		rst_n = 1'h0;
		#1;
		chk_val(rx_good_payload_byte_total, 64'h0);
		chk_val(64'(got), 64'h0);
		chk_val(64'(rx_frame_payload_bytes_strobe), 64'h0);
		@(negedge clk);
		rst_n = 1'h1;
		drive(rows[0], 1'h1);
		@(negedge clk);
		drive(rows[0], 1'h0);
		chk_val(rx_good_payload_byte_total, 64'h002e);
		chk_val(64'(rx_frame_payload_bytes), 64'h002e);
		repeat (2) @(negedge clk);
		close_out();
	end

	initial
	begin
		#20000;
		errors++;
		close_out();
	end
endmodule // testbench
`default_nettype wire
